// ---- verilog/ddc_cfg_pkg.sv ----
// Register map, field layout and tables of the down-converter configuration
package ddc_cfg_pkg;

	// ==========================================================
	// Bus
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Register indexes, byte address is four times the index
	localparam logic [7:0] IDX_BC_MODE = 8'h00;
	localparam logic [7:0] IDX_QUAD_BC = 8'h01;
	localparam logic [7:0] IDX_AD = 8'h02;
	localparam logic [7:0] IDX_IL = 8'h18;
	localparam logic [7:0] IDX_DC = 8'h68;
	localparam logic [7:0] IDX_PAT_SEL = 8'h74;
	localparam logic [7:0] IDX_P1_HI = 8'h75;
	localparam logic [7:0] IDX_P1_LO = 8'h76;
	localparam logic [7:0] IDX_P2_HI = 8'h77;
	localparam logic [7:0] IDX_P2_LO = 8'h78;
	localparam logic [7:0] IDX_QUAD_EN = 8'h80;
	localparam logic [7:0] IDX_STATUS = 8'h81;

	// ==========================================================
	// Storage slots
	localparam int NREG = 11;
	localparam int SLOT_BC_MODE = 0;
	localparam int SLOT_QUAD_BC = 1;
	localparam int SLOT_AD = 2;
	localparam int SLOT_IL = 3;
	localparam int SLOT_DC = 4;
	localparam int SLOT_PAT_SEL = 5;
	localparam int SLOT_P1_HI = 6;
	localparam int SLOT_P1_LO = 7;
	localparam int SLOT_P2_HI = 8;
	localparam int SLOT_P2_LO = 9;
	localparam int SLOT_QUAD_EN = 10;
	localparam logic [7:0] REG_IDX [NREG] = '{IDX_BC_MODE, IDX_QUAD_BC,
		IDX_AD, IDX_IL, IDX_DC, IDX_PAT_SEL, IDX_P1_HI, IDX_P1_LO,
		IDX_P2_HI, IDX_P2_LO, IDX_QUAD_EN};
	// Writable bits, reserved bits read as zero
	localparam logic [7:0] REG_MASK [NREG] = '{8'hFF, 8'h0F, 8'h3F,
		8'h03, 8'h06, 8'hF0, 8'hFF, 8'hFC, 8'hFF, 8'hFC, 8'h03};
	localparam logic [7:0] REG_RESET = 8'h00;

	// ==========================================================
	// Fields
	localparam int STEP_W = 4;
	localparam int BC_STEP_LSB = 4;
	localparam int AD_STEP_LSB = 0;
	localparam int MODE_LSB = 0;
	localparam int MODE_W = 4;
	localparam int QUAD_EN1_BIT = 3;
	localparam int BC_HP_BIT = 1;
	localparam int BC_PH_BIT = 0;
	localparam int AD_HP_BIT = 5;
	localparam int AD_PH_BIT = 4;
	localparam int IL_LSB = 0;
	localparam int DC_LSB = 1;
	localparam int PAT_SEL_LSB = 4;
	localparam int PAT_LOW_LSB = 2;
	localparam int PAT_LOW_W = 6;
	localparam int QUAD_EN2_BIT = 0;
	localparam int QUAD_EN3_BIT = 1;
	localparam int ST_CPX = 0;
	localparam int ST_SHIFT_LSB = 1;
	localparam int ST_MIX = 3;
	localparam int ST_PAT = 4;
	localparam int ST_QUAD_OK = 5;
	localparam int ST_IL_RUN = 6;
	localparam int ST_DC_RUN = 7;

	// ==========================================================
	// Codes
	localparam logic [3:0] MODE_QUARTER = 4'h0;
	localparam logic [3:0] MODE_FILT = 4'h1;
	localparam logic [3:0] MODE_FINE_REAL = 4'h3;
	localparam logic [3:0] MODE_FINE_CPX = 4'h4;
	localparam logic [3:0] MODE_QUAD = 4'h5;
	localparam logic [3:0] MODE_ZERO_INS = 4'h6;
	localparam logic [3:0] MODE_PASS = 4'h7;
	localparam logic [3:0] PAT_SINGLE = 4'h6;
	localparam logic [3:0] PAT_DOUBLE = 4'h7;
	localparam logic [1:0] IL_SKIP = 2'h3;
	localparam logic [1:0] DC_STOP = 2'h3;
	localparam logic [3:0] STEP_PLUS_Q = 4'h4;
	localparam logic [3:0] STEP_MINUS_Q = 4'hC;
	localparam logic [3:0] COS_OFFSET = 4'h4;

	// ==========================================================
	// Datapath widths
	localparam int LANES = 4;
	localparam int SMP_W = 14;
	localparam int OUT_W = 16;
	localparam int ACC_W = 18;
	localparam int PROD_W = 22;
	localparam int COEF_FRAC = 7;

	// Sine of p * 2pi / 16, scaled by 127
	function automatic logic [7:0] sine16(input logic [3:0] p);
		logic [7:0] m;
		case (p[2:0])
			3'h1: m = 8'h31;
			3'h2: m = 8'h5A;
			3'h3: m = 8'h75;
			3'h4: m = 8'h7F;
			3'h5: m = 8'h75;
			3'h6: m = 8'h5A;
			3'h7: m = 8'h31;
			default: m = 8'h00;
		endcase
		return p[3] ? 8'(-m) : m;
	endfunction

endpackage

// ---- verilog/ddc_lane.sv ----
// One lane of mixer, decimating boxcar filter and output register
`timescale 1ns/1ps
module ddc_lane (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic [ddc_cfg_pkg::SMP_W-1:0] sample,
	input wire logic [3:0] phase,
	input wire logic mix_on,
	input wire logic complex_on,
	input wire logic highpass,
	input wire logic start,
	input wire logic dump,
	input wire logic [1:0] shift,
	output logic [ddc_cfg_pkg::OUT_W-1:0] out_i,
	output logic [ddc_cfg_pkg::OUT_W-1:0] out_q,
	output logic out_valid
);
	localparam int AW = ddc_cfg_pkg::ACC_W;
	localparam int PW = ddc_cfg_pkg::PROD_W;
	localparam int CF = ddc_cfg_pkg::COEF_FRAC;
	localparam int SW = ddc_cfg_pkg::SMP_W;

	logic signed [7:0] cosv;
	logic signed [7:0] sinv;
	logic signed [PW-1:0] prod_i;
	logic signed [PW-1:0] prod_q;
	logic signed [AW-1:0] term_i;
	logic signed [AW-1:0] term_q;
	logic signed [AW-1:0] acc_i_q;
	logic signed [AW-1:0] acc_q_q;
	logic signed [AW-1:0] acc_i_d;
	logic signed [AW-1:0] acc_q_d;
	logic signed [AW-1:0] sh_i;
	logic signed [AW-1:0] sh_q;
	logic par_q;

	// ==========================================================
	// Mixer and filter
	assign cosv = ddc_cfg_pkg::sine16(4'(phase + ddc_cfg_pkg::COS_OFFSET));
	assign sinv = ddc_cfg_pkg::sine16(phase);
	assign prod_i = $signed(sample) * cosv;
	assign prod_q = $signed(sample) * sinv;

	always_comb begin
		term_i = {{(AW-SW){sample[SW-1]}}, sample};
		term_q = '0;
		if (mix_on) begin
			term_i = AW'($signed(prod_i[PW-1:CF]));
		end
		if (mix_on && complex_on) begin
			term_q = AW'(-$signed(prod_q[PW-1:CF]));
		end
		// Odd samples negated turn the boxcar into a high-pass
		if (highpass && !start && par_q) begin
			term_i = -term_i;
			term_q = -term_q;
		end
		acc_i_d = start ? term_i : AW'(acc_i_q + term_i);
		acc_q_d = start ? term_q : AW'(acc_q_q + term_q);
		sh_i = acc_i_d >>> shift;
		sh_q = acc_q_d >>> shift;
	end

	// ==========================================================
	// State
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_i_q <= '0;
			acc_q_q <= '0;
			par_q <= 1'b0;
			out_i <= '0;
			out_q <= '0;
			out_valid <= 1'b0;
		end else begin
			out_valid <= 1'b0;
			if (in_valid) begin
				acc_i_q <= acc_i_d;
				acc_q_q <= acc_q_d;
				par_q <= start ? 1'b1 : ~par_q;
				if (dump) begin
					out_i <= sh_i[ddc_cfg_pkg::OUT_W-1:0];
					out_q <= sh_q[ddc_cfg_pkg::OUT_W-1:0];
					out_valid <= 1'b1;
				end
			end
		end
	end
endmodule // ddc_lane

// ---- verilog/ddc_cfg_top.sv ----
// Down-converter mode, mixer and test pattern block behind AXI4-Lite
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module ddc_cfg_top (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic [ddc_cfg_pkg::ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [ddc_cfg_pkg::DATA_W-1:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [ddc_cfg_pkg::ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [ddc_cfg_pkg::DATA_W-1:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic SMP_VALID,
	input wire logic [ddc_cfg_pkg::LANES*ddc_cfg_pkg::SMP_W-1:0] SMP_DATA,
	output logic OUT_VALID,
	output logic [ddc_cfg_pkg::LANES*ddc_cfg_pkg::OUT_W-1:0] OUT_I,
	output logic [ddc_cfg_pkg::LANES*ddc_cfg_pkg::OUT_W-1:0] OUT_Q,
	output logic OUT_COMPLEX,
	output logic INTERLEAVE_FIX_RUN,
	output logic OFFSET_LOOP_RUN
);
	localparam int NREG = ddc_cfg_pkg::NREG;
	localparam int AW = ddc_cfg_pkg::ADDR_W;
	localparam int LANES = ddc_cfg_pkg::LANES;
	localparam int SW = ddc_cfg_pkg::SMP_W;
	localparam int OW = ddc_cfg_pkg::OUT_W;

	// ==========================================================
	// Address decode
	function automatic logic [3:0] slot_of(input logic [AW-1:0] a);
		logic [3:0] s;
		s = 4'(NREG);
		for (int i = 0; i < NREG; i++) begin
			if (a == {2'h0, ddc_cfg_pkg::REG_IDX[i], 2'h0}) begin
				s = 4'(i);
			end
		end
		return s;
	endfunction

	logic [7:0] regs_q [NREG];
	logic aw_full_q;
	logic w_full_q;
	logic [AW-1:0] awaddr_q;
	logic [7:0] wbyte_q;
	logic wlane_q;
	logic aw_take;
	logic w_take;
	logic do_wr;
	logic [3:0] wr_slot;
	logic wr_hit;
	logic ar_take;
	logic [3:0] rd_slot;
	logic rd_status;
	logic [7:0] status;

	// ==========================================================
	// Write channels, address and data taken in either order
	assign aw_take = AWVALID & AWREADY;
	assign w_take = WVALID & WREADY;
	assign do_wr = aw_full_q & w_full_q & ~BVALID;
	assign wr_slot = slot_of(awaddr_q);
	assign wr_hit = wr_slot != 4'(NREG);

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			aw_full_q <= 1'b0;
			awaddr_q <= '0;
			AWREADY <= 1'b0;
		end else begin
			if (aw_take) begin
				awaddr_q <= AWADDR;
			end
			aw_full_q <= (aw_full_q & ~do_wr) | aw_take;
			AWREADY <= ~((aw_full_q & ~do_wr) | aw_take);
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			w_full_q <= 1'b0;
			wbyte_q <= '0;
			wlane_q <= 1'b0;
			WREADY <= 1'b0;
		end else begin
			if (w_take) begin
				wbyte_q <= WDATA[7:0];
				wlane_q <= WSTRB[0];
			end
			w_full_q <= (w_full_q & ~do_wr) | w_take;
			WREADY <= ~((w_full_q & ~do_wr) | w_take);
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			BVALID <= 1'b0;
			BRESP <= ddc_cfg_pkg::RESP_OKAY;
		end else if (do_wr) begin
			BVALID <= 1'b1;
			BRESP <= wr_hit ? ddc_cfg_pkg::RESP_OKAY
				: ddc_cfg_pkg::RESP_SLVERR;
		end else if (BREADY) begin
			BVALID <= 1'b0;
		end
	end

	// ==========================================================
	// Register storage
	// Masking keeps reserved bits at zero whatever is written
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			for (int i = 0; i < NREG; i++) begin
				regs_q[i] <= ddc_cfg_pkg::REG_RESET;
			end
		end else if (do_wr && wr_hit && wlane_q) begin
			regs_q[wr_slot] <= wbyte_q
				& ddc_cfg_pkg::REG_MASK[wr_slot];
		end
	end

	// ==========================================================
	// Read channel
	assign ar_take = ARVALID & ARREADY;
	assign rd_slot = slot_of(ARADDR);
	assign rd_status = ARADDR == {2'h0, ddc_cfg_pkg::IDX_STATUS, 2'h0};

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ARREADY <= 1'b0;
			RVALID <= 1'b0;
			RDATA <= '0;
			RRESP <= ddc_cfg_pkg::RESP_OKAY;
		end else begin
			ARREADY <= ~(ar_take | (RVALID & ~RREADY));
			if (ar_take) begin
				RVALID <= 1'b1;
				RRESP <= ddc_cfg_pkg::RESP_OKAY;
				if (rd_status) begin
					RDATA <= {24'h00_0000, status};
				end else if (rd_slot != 4'(NREG)) begin
					RDATA <= {24'h00_0000, regs_q[rd_slot]};
				end else begin
					RDATA <= '0;
					RRESP <= ddc_cfg_pkg::RESP_SLVERR;
				end
			end else if (RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Fields
	logic [3:0] mode;
	logic [3:0] bc_fine;
	logic [3:0] ad_fine;
	logic bc_hp;
	logic ad_hp;
	logic bc_minus;
	logic ad_minus;
	logic [1:0] il_field;
	logic [1:0] dc_field;
	logic [3:0] pat_sel;
	logic [SW-1:0] pat_one;
	logic [SW-1:0] pat_two;
	logic quad_ok;

	assign mode = regs_q[ddc_cfg_pkg::SLOT_BC_MODE]
		[ddc_cfg_pkg::MODE_LSB +: ddc_cfg_pkg::MODE_W];
	assign bc_fine = regs_q[ddc_cfg_pkg::SLOT_BC_MODE]
		[ddc_cfg_pkg::BC_STEP_LSB +: ddc_cfg_pkg::STEP_W];
	assign ad_fine = regs_q[ddc_cfg_pkg::SLOT_AD]
		[ddc_cfg_pkg::AD_STEP_LSB +: ddc_cfg_pkg::STEP_W];
	assign bc_hp = regs_q[ddc_cfg_pkg::SLOT_QUAD_BC][ddc_cfg_pkg::BC_HP_BIT];
	assign ad_hp = regs_q[ddc_cfg_pkg::SLOT_AD][ddc_cfg_pkg::AD_HP_BIT];
	assign bc_minus = regs_q[ddc_cfg_pkg::SLOT_QUAD_BC]
		[ddc_cfg_pkg::BC_PH_BIT];
	assign ad_minus = regs_q[ddc_cfg_pkg::SLOT_AD][ddc_cfg_pkg::AD_PH_BIT];
	assign il_field = regs_q[ddc_cfg_pkg::SLOT_IL]
		[ddc_cfg_pkg::IL_LSB +: 2];
	assign dc_field = regs_q[ddc_cfg_pkg::SLOT_DC]
		[ddc_cfg_pkg::DC_LSB +: 2];
	assign pat_sel = regs_q[ddc_cfg_pkg::SLOT_PAT_SEL]
		[ddc_cfg_pkg::PAT_SEL_LSB +: 4];
	assign pat_one = {regs_q[ddc_cfg_pkg::SLOT_P1_HI],
		regs_q[ddc_cfg_pkg::SLOT_P1_LO]
		[ddc_cfg_pkg::PAT_LOW_LSB +: ddc_cfg_pkg::PAT_LOW_W]};
	assign pat_two = {regs_q[ddc_cfg_pkg::SLOT_P2_HI],
		regs_q[ddc_cfg_pkg::SLOT_P2_LO]
		[ddc_cfg_pkg::PAT_LOW_LSB +: ddc_cfg_pkg::PAT_LOW_W]};
	// Decimate-by-4 still runs without them; software is told here
	assign quad_ok = regs_q[ddc_cfg_pkg::SLOT_QUAD_BC]
		[ddc_cfg_pkg::QUAD_EN1_BIT]
		& regs_q[ddc_cfg_pkg::SLOT_QUAD_EN][ddc_cfg_pkg::QUAD_EN2_BIT]
		& regs_q[ddc_cfg_pkg::SLOT_QUAD_EN]
		[ddc_cfg_pkg::QUAD_EN3_BIT];

	// ==========================================================
	// Mode decode
	logic mix_quarter;
	logic mix_fine;
	logic complex_on;
	logic zero_ins;
	logic filt_mode;
	logic [1:0] shift;

	always_comb begin
		mix_quarter = 1'b0;
		mix_fine = 1'b0;
		complex_on = 1'b0;
		zero_ins = 1'b0;
		filt_mode = 1'b0;
		shift = 2'h1;
		case (mode)
			ddc_cfg_pkg::MODE_QUARTER: begin
				mix_quarter = 1'b1;
				complex_on = 1'b1;
			end
			ddc_cfg_pkg::MODE_FILT: begin
				filt_mode = 1'b1;
			end
			ddc_cfg_pkg::MODE_FINE_REAL: begin
				mix_fine = 1'b1;
			end
			ddc_cfg_pkg::MODE_FINE_CPX: begin
				mix_fine = 1'b1;
				complex_on = 1'b1;
			end
			ddc_cfg_pkg::MODE_QUAD: begin
				mix_fine = 1'b1;
				complex_on = 1'b1;
				shift = 2'h2;
			end
			ddc_cfg_pkg::MODE_ZERO_INS: begin
				mix_fine = 1'b1;
				zero_ins = 1'b1;
			end
			default: begin
				// Unused codes fall back to pass-through
				shift = 2'h0;
			end
		endcase
	end

	// ==========================================================
	// Phase and decimation counters
	logic [3:0] bc_step;
	logic [3:0] ad_step;
	logic [3:0] bc_ph_q;
	logic [3:0] ad_ph_q;
	logic [1:0] cnt_q;
	logic [1:0] dec_last;
	logic start;
	logic dump;
	logic restart;

	always_comb begin
		bc_step = 4'h0;
		ad_step = 4'h0;
		if (mix_quarter) begin
			bc_step = bc_minus ? ddc_cfg_pkg::STEP_MINUS_Q
				: ddc_cfg_pkg::STEP_PLUS_Q;
			ad_step = ad_minus ? ddc_cfg_pkg::STEP_MINUS_Q
				: ddc_cfg_pkg::STEP_PLUS_Q;
		end else if (mix_fine) begin
			bc_step = bc_fine;
			ad_step = ad_fine;
		end
	end

	assign dec_last = 2'((3'h1 << shift) - 3'h1);
	assign start = cnt_q == 2'h0;
	assign dump = cnt_q == dec_last;
	// A new mode must not inherit a half-filled window
	assign restart = do_wr & wlane_q
		& (wr_slot == 4'(ddc_cfg_pkg::SLOT_BC_MODE));

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			cnt_q <= 2'h0;
			bc_ph_q <= 4'h0;
			ad_ph_q <= 4'h0;
		end else if (restart) begin
			cnt_q <= 2'h0;
			bc_ph_q <= 4'h0;
			ad_ph_q <= 4'h0;
		end else if (SMP_VALID) begin
			cnt_q <= dump ? 2'h0 : 2'(cnt_q + 2'h1);
			// Steps wrap mod 16, so 1000 is -8 and 1111 is -1
			bc_ph_q <= 4'(bc_ph_q + bc_step);
			ad_ph_q <= 4'(ad_ph_q + ad_step);
		end
	end

	// ==========================================================
	// Test pattern source
	logic pat_on;
	logic alt_q;
	logic [SW-1:0] pat_word;

	assign pat_on = (pat_sel == ddc_cfg_pkg::PAT_SINGLE)
		| (pat_sel == ddc_cfg_pkg::PAT_DOUBLE);
	assign pat_word = alt_q ? pat_two : pat_one;

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			alt_q <= 1'b0;
		end else if (pat_sel != ddc_cfg_pkg::PAT_DOUBLE) begin
			alt_q <= 1'b0;
		end else if (SMP_VALID) begin
			alt_q <= ~alt_q;
		end
	end

	// ==========================================================
	// Lanes: A and D share one mixer, B and C the other
	logic [OW-1:0] lane_i [LANES];
	logic [OW-1:0] lane_q [LANES];
	logic [LANES-1:0] lane_valid;

	for (genvar g = 0; g < LANES; g++) begin : g_lane
		localparam bit IS_AD = (g == 0) || (g == LANES - 1);
		ddc_lane u_lane (
			.clk(CLK),
			.rst(SYS_RST),
			.in_valid(SMP_VALID),
			.sample(pat_on ? pat_word : SMP_DATA[g*SW +: SW]),
			.phase(IS_AD ? ad_ph_q : bc_ph_q),
			.mix_on(mix_quarter | mix_fine),
			.complex_on(complex_on),
			.highpass(filt_mode & (IS_AD ? ad_hp : bc_hp)),
			.start(start),
			.dump(dump),
			.shift(shift),
			.out_i(lane_i[g]),
			.out_q(lane_q[g]),
			.out_valid(lane_valid[g])
		);
	end

	// ==========================================================
	// Output stage
	logic zpend_q;

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			OUT_VALID <= 1'b0;
			OUT_I <= '0;
			OUT_Q <= '0;
			zpend_q <= 1'b0;
		end else begin
			OUT_VALID <= 1'b0;
			if (lane_valid[0]) begin
				for (int i = 0; i < LANES; i++) begin
					OUT_I[i*OW +: OW] <= lane_i[i];
					OUT_Q[i*OW +: OW] <= lane_q[i];
				end
				OUT_VALID <= 1'b1;
				zpend_q <= zero_ins;
			end else if (zpend_q && SMP_VALID) begin
				OUT_I <= '0;
				OUT_Q <= '0;
				OUT_VALID <= 1'b1;
				zpend_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			OUT_COMPLEX <= 1'b0;
			INTERLEAVE_FIX_RUN <= 1'b1;
			OFFSET_LOOP_RUN <= 1'b1;
		end else begin
			OUT_COMPLEX <= complex_on;
			INTERLEAVE_FIX_RUN <= il_field != ddc_cfg_pkg::IL_SKIP;
			OFFSET_LOOP_RUN <= dc_field != ddc_cfg_pkg::DC_STOP;
		end
	end

	// ==========================================================
	// Status
	always_comb begin
		status = 8'h00;
		status[ddc_cfg_pkg::ST_CPX] = complex_on;
		status[ddc_cfg_pkg::ST_SHIFT_LSB +: 2] = shift;
		status[ddc_cfg_pkg::ST_MIX] = mix_quarter | mix_fine;
		status[ddc_cfg_pkg::ST_PAT] = pat_on;
		status[ddc_cfg_pkg::ST_QUAD_OK] = quad_ok;
		status[ddc_cfg_pkg::ST_IL_RUN] = INTERLEAVE_FIX_RUN;
		status[ddc_cfg_pkg::ST_DC_RUN] = OFFSET_LOOP_RUN;
	end
endmodule // ddc_cfg_top

// ---- bench/conv_core_model.sv ----
// Conversion core stand-in feeding four lanes of samples
`timescale 1ns/1ps
module conv_core_model (
	input wire logic clk,
	input wire logic go,
	input wire logic [55:0] lanes,
	output logic smp_valid,
	output logic [55:0] smp_data
);
	// ==========================================================
	// Sample launch
	initial begin
		smp_valid = 1'b0;
		smp_data = 56'h0;
	end
	// Idle lanes flip every cycle, so a stale word never passes as data
	always @(posedge clk) begin
		smp_valid <= go;
		smp_data <= go ? lanes : ~smp_data;
	end
endmodule // conv_core_model

// ---- bench/ddc_cfg_top_properties.sv ----
// Assertions on the ports of the configuration block
`timescale 1ns/1ps
module ddc_cfg_checker (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic [1:0] BRESP,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [ddc_cfg_pkg::DATA_W-1:0] RDATA,
	input wire logic RVALID,
	input wire logic RREADY,
	input wire logic SMP_VALID,
	input wire logic OUT_VALID,
	input wire logic [ddc_cfg_pkg::LANES*ddc_cfg_pkg::OUT_W-1:0] OUT_Q,
	input wire logic OUT_COMPLEX,
	input wire logic INTERLEAVE_FIX_RUN,
	input wire logic OFFSET_LOOP_RUN
);
	// ==========================================================
	// Handshake steps
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	sequence wr_taken;
		AWVALID && AWREADY && WVALID && WREADY;
	endsequence
	sequence rd_taken;
		ARVALID && ARREADY;
	endsequence
	// ==========================================================
	// Register bus
	aw_refuse_a: assert property (
		AWVALID && AWREADY |=> !AWREADY) else $error("address taken twice");
	bresp_due_a: assert property (
		wr_taken |-> ##[1:2] BVALID) else $error("write response late");
	bresp_hold_a: assert property (
		BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped");
	bresp_end_a: assert property (
		BVALID && BREADY |=> !BVALID) else $error("write response repeated");
	rdata_due_a: assert property (
		rd_taken |=> RVALID) else $error("read data late");
	rdata_hold_a: assert property (
		RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("read data dropped");
	rdata_byte_a: assert property (
		RVALID |-> RDATA[31:8] == 24'h0) else $error("upper read bits set");
	// ==========================================================
	// Stream and flags
	real_q_zero_a: assert property (
		OUT_VALID && !OUT_COMPLEX |-> OUT_Q == '0)
		else $error("real output has Q data");
	out_cause_a: assert property (
		OUT_VALID |-> $past(SMP_VALID, 2)) else $error("output without sample");
	flag_write_a: assert property (
		$changed(INTERLEAVE_FIX_RUN) || $changed(OFFSET_LOOP_RUN)
		|-> BVALID || $past(BVALID)) else $error("flag moved without write");
endmodule // ddc_cfg_checker

bind ddc_cfg_top ddc_cfg_checker chk (.CLK(CLK), .SYS_RST(SYS_RST),
	.AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
	.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
	.ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY),
	.SMP_VALID(SMP_VALID), .OUT_VALID(OUT_VALID), .OUT_Q(OUT_Q),
	.OUT_COMPLEX(OUT_COMPLEX), .INTERLEAVE_FIX_RUN(INTERLEAVE_FIX_RUN),
	.OFFSET_LOOP_RUN(OFFSET_LOOP_RUN));

// ---- bench/test_ddc_cfg_top.sv ----
// Self-checking bench for the down-converter configuration block
`timescale 1ns/1ps
module test_ddc_cfg_top;
	logic CLK, SYS_RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, go;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SMP_VALID, OUT_VALID;
	logic OUT_COMPLEX, INTERLEAVE_FIX_RUN, OFFSET_LOOP_RUN;
	logic [11:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP;
	logic [55:0] SMP_DATA, lanes;
	logic [63:0] OUT_I, OUT_Q;
	logic [63:0] qi[$], qq[$];
	logic qc[$];
	logic [13:0] p1, p2, s;
	logic [7:0] d;
	int num_errors, n_checks, cyc;

	ddc_cfg_top dut (.CLK(CLK), .SYS_RST(SYS_RST), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
		.BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
		.RREADY(RREADY), .SMP_VALID(SMP_VALID), .SMP_DATA(SMP_DATA),
		.OUT_VALID(OUT_VALID), .OUT_I(OUT_I), .OUT_Q(OUT_Q),
		.OUT_COMPLEX(OUT_COMPLEX), .INTERLEAVE_FIX_RUN(INTERLEAVE_FIX_RUN),
		.OFFSET_LOOP_RUN(OFFSET_LOOP_RUN));
	conv_core_model core (.clk(CLK), .go(go), .lanes(lanes),
		.smp_valid(SMP_VALID), .smp_data(SMP_DATA));

	// ==========================================================
	// Clock, capture, timeout
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		if (OUT_VALID) begin
			qi.push_back(OUT_I);
			qq.push_back(OUT_Q);
			qc.push_back(OUT_COMPLEX);
		end
		cyc++;
		if (cyc == 6000) begin
			num_errors++;
			test_done();
		end
	end

	// ==========================================================
	// Helpers
	function automatic logic [63:0] q4(input logic [15:0] a, b);
		return {a, b, b, a};
	endfunction
	function automatic logic [15:0] sx(input logic [13:0] v);
		return {{2{v[13]}}, v};
	endfunction
	task automatic chk(input string nm, input logic [63:0] e, g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] i, v, input logic [1:0] er);
		logic a, w;
		@(posedge CLK);
		AWADDR <= {2'h0, i, 2'h0};
		WDATA <= {24'h0, v};
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		a = 1'b0;
		w = 1'b0;
		while (!(a && w)) begin
			@(posedge CLK);
			if (AWREADY && AWVALID) begin
				a = 1'b1;
				AWVALID <= 1'b0;
			end
			if (WREADY && WVALID) begin
				w = 1'b1;
				WVALID <= 1'b0;
			end
		end
		do @(posedge CLK); while (BVALID !== 1'b1);
		chk("bresp", er, BRESP);
		BREADY <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] i, e, input logic [1:0] er);
		@(posedge CLK);
		ARADDR <= {2'h0, i, 2'h0};
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do @(posedge CLK); while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		do @(posedge CLK); while (RVALID !== 1'b1);
		chk("rdata", {24'h0, e}, RDATA);
		chk("rresp", er, RRESP);
		RREADY <= 1'b0;
	endtask
	// Mode is written last: that write restarts windows and phases
	task automatic cfg(input logic [7:0] m, ad, bc);
		wr(ddc_cfg_pkg::IDX_QUAD_BC, bc, ddc_cfg_pkg::RESP_OKAY);
		wr(ddc_cfg_pkg::IDX_AD, ad, ddc_cfg_pkg::RESP_OKAY);
		wr(ddc_cfg_pkg::IDX_BC_MODE, m, ddc_cfg_pkg::RESP_OKAY);
		qi.delete();
		qq.delete();
		qc.delete();
	endtask
	task automatic feed(input int n, input logic [13:0] v);
		repeat (n) begin
			@(posedge CLK);
			go <= 1'b1;
			lanes <= {4{v}};
		end
		@(posedge CLK);
		go <= 1'b0;
		repeat (6) @(posedge CLK);
	endtask
	task automatic expo(input logic [63:0] ei, eq, input logic ec);
		if (qi.size() == 0) begin
			chk("output count", 64'h1, 64'h0);
			return;
		end
		chk("out_i", ei, qi.pop_front());
		chk("out_q", eq, qq.pop_front());
		chk("out_complex", {63'h0, ec}, {63'h0, qc.pop_front()});
	endtask
	task automatic test_done();
		if (num_errors == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		{AWVALID, WVALID, BREADY, ARVALID, RREADY, go} = 6'h0;
		{AWADDR, ARADDR, WDATA, lanes} = '0;
		WSTRB = 4'hF;
		SYS_RST = 1'b1;
		void'($urandom(13288));
		repeat (8) @(posedge CLK);
		SYS_RST <= 1'b0;
		for (int k = 0; k < ddc_cfg_pkg::NREG; k++) begin
			rd(ddc_cfg_pkg::REG_IDX[k], 8'h00, 2'h0);
			d = 8'($urandom()) & ddc_cfg_pkg::REG_MASK[k];
			if (k == ddc_cfg_pkg::SLOT_BC_MODE) d[3] = 1'b0;
			if (k == ddc_cfg_pkg::SLOT_QUAD_BC) d[2] = 1'b1;
			if (k == ddc_cfg_pkg::SLOT_DC) d[2:1] = {2{d[1]}};
			wr(ddc_cfg_pkg::REG_IDX[k], d, 2'h0);
			rd(ddc_cfg_pkg::REG_IDX[k], d, 2'h0);
		end
		rd(8'h30, 8'h00, ddc_cfg_pkg::RESP_SLVERR);
		wr(8'h30, 8'h5A, ddc_cfg_pkg::RESP_SLVERR);
		wr(ddc_cfg_pkg::IDX_STATUS, 8'h01, ddc_cfg_pkg::RESP_SLVERR);
		for (int v = 3; v >= 0; v -= 3) begin
			wr(ddc_cfg_pkg::IDX_IL, 8'(v), 2'h0);
			wr(ddc_cfg_pkg::IDX_DC, 8'(v * 2), 2'h0);
			// Flags are registered one edge after the field lands
			@(posedge CLK);
			chk("il run", 64'(v != 3), 64'(INTERLEAVE_FIX_RUN));
			chk("dc run", 64'(v != 3), 64'(OFFSET_LOOP_RUN));
		end
		// Random select may have left a pattern on
		wr(ddc_cfg_pkg::IDX_PAT_SEL, 8'h00, 2'h0);
		cfg({4'h0, ddc_cfg_pkg::MODE_PASS}, 8'h00, 8'h04);
		repeat (4) begin
			s = 14'($urandom());
			feed(1, s);
			expo(q4(sx(s), sx(s)), 64'h0, 1'b0);
		end
		// Test patterns want the interleave fix bypassed
		wr(ddc_cfg_pkg::IDX_IL, 8'h03, 2'h0);
		p1 = 14'($urandom());
		p2 = 14'($urandom());
		wr(ddc_cfg_pkg::IDX_P1_HI, p1[13:6], 2'h0);
		wr(ddc_cfg_pkg::IDX_P1_LO, {p1[5:0], 2'h0}, 2'h0);
		wr(ddc_cfg_pkg::IDX_P2_HI, p2[13:6], 2'h0);
		wr(ddc_cfg_pkg::IDX_P2_LO, {p2[5:0], 2'h0}, 2'h0);
		wr(ddc_cfg_pkg::IDX_PAT_SEL, 8'h60, 2'h0);
		feed(1, s);
		expo(q4(sx(p1), sx(p1)), 64'h0, 1'b0);
		wr(ddc_cfg_pkg::IDX_PAT_SEL, 8'h70, 2'h0);
		feed(3, s);
		expo(q4(sx(p1), sx(p1)), 64'h0, 1'b0);
		expo(q4(sx(p2), sx(p2)), 64'h0, 1'b0);
		expo(q4(sx(p1), sx(p1)), 64'h0, 1'b0);
		wr(ddc_cfg_pkg::IDX_PAT_SEL, 8'h00, 2'h0);
		wr(ddc_cfg_pkg::IDX_IL, 8'h00, 2'h0);
		cfg(8'h01, 8'h00, 8'h06);
		feed(2, 14'h0100);
		expo(q4(16'h0100, 16'h0), 64'h0, 1'b0);
		cfg(8'h01, 8'h20, 8'h04);
		feed(2, 14'h0100);
		expo(q4(16'h0, 16'h0100), 64'h0, 1'b0);
		cfg(8'h00, 8'h10, 8'h04);
		feed(2, 14'h0100);
		expo(q4(16'h7F, 16'h7F), q4(16'h7F, 16'hFF81), 1'b1);
		cfg(8'h44, 8'h0C, 8'h04);
		feed(2, 14'h0100);
		expo(q4(16'h7F, 16'h7F), q4(16'h7F, 16'hFF81), 1'b1);
		cfg(8'h43, 8'h0C, 8'h04);
		feed(2, 14'h0100);
		expo(q4(16'h7F, 16'h7F), 64'h0, 1'b0);
		wr(ddc_cfg_pkg::IDX_QUAD_EN, 8'h03, 2'h0);
		cfg(8'h05, 8'h00, 8'h0C);
		feed(4, 14'h0100);
		expo(q4(16'hFE, 16'hFE), 64'h0, 1'b1);
		rd(ddc_cfg_pkg::IDX_STATUS, 8'hED, 2'h0);
		cfg(8'h06, 8'h00, 8'h04);
		// Zero slot needs a sample after the output
		feed(4, 14'h0100);
		expo(q4(16'hFE, 16'hFE), 64'h0, 1'b0);
		expo(64'h0, 64'h0, 1'b0);
		test_done();
	end
endmodule // test_ddc_cfg_top
